/* File: scan_term_pkg.sv */
// Function
// - Run command starts back-to-back scanned measurements until stopped or terminated.
// - Run-off stops continuous measurements; device idles awaiting a new command.
// - Run argument 1 means on, 0 off; omitted argument means on.
// - Commands interrupt a run; run resumes except after run-off, single-advance or single-shot.
// - Run starts from current coupled values, no re-initialisation; counters are kept only while total is zero.
// - No coupled parameter enabled: run refused with no-coupled-parameter error.
// - Single-advance or single-shot stop; counters hold completed measurement counter_clear_qualifier.
// - Four counters: each measurement, and first, second, third loop passes.
// - Counter_clear_qualifier qualifier of reset clears all four counters to zero.
// - Coupled qualifier returns every coupled parameter to its scan starting value.
// - All qualifier, or no qualifier, does both counter clear and coupled return.
// - Counters are read-only to the host and never loaded.
// - Nonzero total ends the run when the selected counter reaches it.
// - Nonzero total clears all counters whenever a run-on command is accepted.
// - Zero total (default) disables auto-termination; counters still count; host stops run.
// - Termination select picks each, first, second or third loop counter; default each.
// - Each selection: total equals number of individual measurements.
// - First_loop_select selection: total counter_clear_qualifier first-loop passes, total times first set size.
// - Second selection: total counter_clear_qualifier second-loop passes.
// - Third selection: total counter_clear_qualifier third-loop passes.
// - Select value above coupled parameter count is rejected with select-too-large error.
// - Lowest-order parameter steps before each measurement; higher ones on lower wrap.
// - Measurements happen only while at least one coupling order is nonzero.
package scan_term_pkg;

  localparam int CNT_W = 32;
  localparam int NUM_PARAMS = 3;
  localparam int ORDER_W = 2;
  localparam logic [CNT_W-1:0] TOTAL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [1:0] LEVEL_RESET = 2'h0;

  typedef enum logic [2:0] {
    CMD_RUN = 3'h0,
    CMD_RESET = 3'h1,
    CMD_SET_TOTAL = 3'h2,
    CMD_SET_SELECT = 3'h3,
    CMD_SINGLE_ADVANCE = 3'h4,
    CMD_SINGLE_SHOT = 3'h5,
    CMD_OTHER = 3'h6
  } cmd_code_t;

  typedef enum logic [1:0] {
    QUAL_ALL = 2'h0,
    QUAL_COUNTER_CLEAR_QUALIFIER = 2'h1,
    QUAL_COUPLED = 2'h2
  } reset_qual_t;

  typedef enum logic [1:0] {
    SEL_EACH = 2'h0,
    SEL_FIRST = 2'h1,
    SEL_SECOND = 2'h2,
    SEL_THIRD = 2'h3
  } term_sel_t;

  localparam term_sel_t SELECT_RESET = SEL_EACH;

  typedef struct packed {
    cmd_code_t code;
    logic argPresent;
    logic argOn;
    reset_qual_t qual;
    logic [CNT_W-1:0] value;
  } scan_cmd_t;

  typedef struct packed {
    logic [CNT_W-1:0] each;
    logic [CNT_W-1:0] firstLoop;
    logic [CNT_W-1:0] secondLoop;
    logic [CNT_W-1:0] thirdLoop;
  } run_counters_t;

  typedef logic [NUM_PARAMS-1:0][ORDER_W-1:0] couple_orders_t;

endpackage : scan_term_pkg

/* File: coupling_order_map.sv */
module coupling_order_map (
  input wire scan_term_pkg::couple_orders_t coupleOrder,
  output logic [2:0][1:0] levelParam,
  output logic [1:0] coupledCount
);
  import scan_term_pkg::*;

  function automatic logic isCoupled(input logic [ORDER_W-1:0] order);
    isCoupled = order != 2'h0;
  endfunction : isCoupled

  // Orders are distinct when nonzero, so rank is the count of lower nonzero orders
  always_comb begin
    logic [1:0] rank;
    rank = 2'h0;
    levelParam = '0;
    coupledCount = 2'h0;
    for (int p = 0; p < NUM_PARAMS; p++) begin
      if (isCoupled(coupleOrder[p])) begin
        coupledCount = coupledCount + 2'h1;
        rank = 2'h0;
        for (int q = 0; q < NUM_PARAMS; q++) begin
          if (q != p && isCoupled(coupleOrder[q]) && coupleOrder[q] < coupleOrder[p]) begin
            rank = rank + 2'h1;
          end
        end
        levelParam[rank] = 2'(p);
      end
    end
  end

endmodule : coupling_order_map

/* File: scan_sequence_terminator.sv */
module scan_sequence_terminator (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cmdValid,
  input wire scan_term_pkg::scan_cmd_t cmd,
  output logic cmdReady,
  input wire scan_term_pkg::couple_orders_t coupleOrder,
  output logic [scan_term_pkg::NUM_PARAMS-1:0] stepReq,
  input wire logic stepAck,
  input wire logic [scan_term_pkg::NUM_PARAMS-1:0] stepWrap,
  input wire logic [scan_term_pkg::NUM_PARAMS-1:0] stepLast,
  output logic coupledRestart,
  output logic measStart,
  input wire logic measDone,
  output scan_term_pkg::run_counters_t runCounters,
  output logic [scan_term_pkg::CNT_W-1:0] terminationTotal,
  output scan_term_pkg::term_sel_t terminationSelect,
  output logic runActive,
  output logic runEnded,
  output logic noCoupledParamError,
  output logic selectTooLargeError
);
  import scan_term_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STEP = 3'b001,
    ST_STEP_WAIT = 3'b011,
    ST_MEAS = 3'b010,
    ST_MEAS_WAIT = 3'b110,
    ST_GAP = 3'b111
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [2:0][1:0] levelParam;
  logic [1:0] coupledCount;
  logic [1:0] level_q;
  logic [2:0] lastAt_q;
  run_counters_t counters_q;
  run_counters_t ctrNext;
  logic [CNT_W-1:0] total_q;
  term_sel_t select_q;
  logic [NUM_PARAMS-1:0] stepReq_q;
  logic measStart_q;
  logic coupledRestart_q;
  logic runEnded_q;
  logic noCoupledErr_q;
  logic selTooBigErr_q;
  logic cmdFire;
  logic runOn;
  logic runOff;
  logic anyCoupled;
  logic runStart;
  logic stopCmd;
  logic clearCounts;
  logic restartCoupled;
  logic measFinish;
  logic autoStop;
  logic stepFinish;
  logic cascade;
  logic [1:0] curParam;

  function automatic logic [CNT_W-1:0] selectCount(input run_counters_t c, input term_sel_t s);
    case (s)
      SEL_EACH: selectCount = c.each;
      SEL_FIRST: selectCount = c.firstLoop;
      SEL_SECOND: selectCount = c.secondLoop;
      SEL_THIRD: selectCount = c.thirdLoop;
      default: selectCount = c.each;
    endcase
  endfunction : selectCount

  function automatic logic [NUM_PARAMS-1:0] oneHot(input logic [1:0] idx);
    oneHot = '0;
    oneHot[idx] = 1'b1;
  endfunction : oneHot

  coupling_order_map orderMap (
    .coupleOrder(coupleOrder),
    .levelParam(levelParam),
    .coupledCount(coupledCount)
  );

  // Commands only land between measurements, so a step or measurement is never torn
  assign cmdReady = (state_q == ST_IDLE) || (state_q == ST_GAP);
  assign cmdFire = cmdValid && cmdReady;
  assign anyCoupled = coupledCount != 2'h0;

  always_comb begin
    runOn = 1'b0;
    runOff = 1'b0;
    if (cmd.code == CMD_RUN) begin
      runOn = !cmd.argPresent || cmd.argOn;
      runOff = cmd.argPresent && !cmd.argOn;
    end
  end

  assign runStart = cmdFire && runOn && anyCoupled;
  assign stopCmd = cmdFire && (runOff || cmd.code == CMD_SINGLE_ADVANCE
                   || cmd.code == CMD_SINGLE_SHOT);

  always_comb begin
    clearCounts = 1'b0;
    restartCoupled = 1'b0;
    if (cmdFire && cmd.code == CMD_RESET) begin
      clearCounts = (cmd.qual == QUAL_COUNTER_CLEAR_QUALIFIER) || (cmd.qual == QUAL_ALL);
      restartCoupled = (cmd.qual == QUAL_COUPLED) || (cmd.qual == QUAL_ALL);
    end
  end

  assign curParam = levelParam[level_q];
  assign stepFinish = (state_q == ST_STEP_WAIT) && stepAck;
  // Higher level only steps when the level below it wrapped
  assign cascade = stepWrap[curParam] && (3'(level_q) + 3'h1 < 3'(coupledCount));
  assign measFinish = (state_q == ST_MEAS_WAIT) && measDone;

  // A loop pass completes when its own level and every level below it sat on its last value
  always_comb begin
    ctrNext = counters_q;
    ctrNext.each = counters_q.each + 1'b1;
    if (lastAt_q[0]) begin
      ctrNext.firstLoop = counters_q.firstLoop + 1'b1;
    end
    if (lastAt_q[0] && lastAt_q[1] && coupledCount >= 2'h2) begin
      ctrNext.secondLoop = counters_q.secondLoop + 1'b1;
    end
    if (lastAt_q[0] && lastAt_q[1] && lastAt_q[2] && coupledCount == 2'h3) begin
      ctrNext.thirdLoop = counters_q.thirdLoop + 1'b1;
    end
  end

  // Zero total never matches, counting simply goes on
  assign autoStop = (total_q != TOTAL_RESET)
                    && (selectCount(ctrNext, select_q) == total_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (runStart) begin
          state_d = ST_STEP;
        end
      end
      ST_STEP: begin
        state_d = ST_STEP_WAIT;
      end
      ST_STEP_WAIT: begin
        if (stepAck) begin
          state_d = cascade ? ST_STEP : ST_MEAS;
        end
      end
      ST_MEAS: begin
        state_d = ST_MEAS_WAIT;
      end
      ST_MEAS_WAIT: begin
        if (measDone) begin
          state_d = autoStop ? ST_IDLE : ST_GAP;
        end
      end
      ST_GAP: begin
        if (stopCmd) begin
          state_d = ST_IDLE;
        end else if (cmdFire) begin
          state_d = ST_GAP;
        end else if (!anyCoupled) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_STEP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Level pointer restarts at the lowest order before every measurement
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= LEVEL_RESET;
    end else if (stepFinish && cascade) begin
      level_q <= level_q + 2'h1;
    end else if (state_q == ST_MEAS) begin
      level_q <= LEVEL_RESET;
    end
  end

  // Last-of-set flags survive levels that did not step this time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lastAt_q <= 3'h0;
    end else if (restartCoupled) begin
      lastAt_q <= 3'h0;
    end else if (stepFinish) begin
      lastAt_q[level_q] <= stepLast[curParam];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stepReq_q <= '0;
    end else if (state_q == ST_STEP) begin
      stepReq_q <= oneHot(curParam);
    end else begin
      stepReq_q <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      measStart_q <= 1'b0;
    end else begin
      measStart_q <= (state_q == ST_MEAS) && anyCoupled;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      coupledRestart_q <= 1'b0;
    end else begin
      coupledRestart_q <= restartCoupled;
    end
  end

  // Counters have no load path from the host at all
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counters_q <= '{COUNT_RESET, COUNT_RESET, COUNT_RESET, COUNT_RESET};
    end else if (clearCounts) begin
      counters_q <= '{COUNT_RESET, COUNT_RESET, COUNT_RESET, COUNT_RESET};
    end else if (runStart && total_q != TOTAL_RESET) begin
      counters_q <= '{COUNT_RESET, COUNT_RESET, COUNT_RESET, COUNT_RESET};
    end else if (measFinish) begin
      counters_q <= ctrNext;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      total_q <= TOTAL_RESET;
    end else if (cmdFire && cmd.code == CMD_SET_TOTAL) begin
      total_q <= cmd.value;
    end
  end

  // Out-of-range select leaves the old choice in place
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      select_q <= SELECT_RESET;
    end else if (cmdFire && cmd.code == CMD_SET_SELECT && cmd.value <= CNT_W'(coupledCount)) begin
      select_q <= term_sel_t'(cmd.value[1:0]);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      selTooBigErr_q <= 1'b0;
    end else begin
      selTooBigErr_q <= cmdFire && cmd.code == CMD_SET_SELECT
                        && cmd.value > CNT_W'(coupledCount);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      noCoupledErr_q <= 1'b0;
    end else begin
      noCoupledErr_q <= cmdFire && runOn && !anyCoupled;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      runEnded_q <= 1'b0;
    end else begin
      runEnded_q <= measFinish && autoStop;
    end
  end

  assign stepReq = stepReq_q;
  assign measStart = measStart_q;
  assign coupledRestart = coupledRestart_q;
  assign runCounters = counters_q;
  assign terminationTotal = total_q;
  assign terminationSelect = select_q;
  assign runActive = state_q != ST_IDLE;
  assign runEnded = runEnded_q;
  assign noCoupledParamError = noCoupledErr_q;
  assign selectTooLargeError = selTooBigErr_q;

endmodule : scan_sequence_terminator

/* File: scan_term_chk.sv */
module scan_term_chk
  import scan_term_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cmdReady,
  input wire scan_term_pkg::couple_orders_t coupleOrder,
  input wire logic [scan_term_pkg::NUM_PARAMS-1:0] stepReq,
  input wire logic measStart,
  input wire scan_term_pkg::run_counters_t runCounters,
  input wire logic [scan_term_pkg::CNT_W-1:0] terminationTotal,
  input wire scan_term_pkg::term_sel_t terminationSelect,
  input wire logic runActive,
  input wire logic runEnded,
  input wire logic noCoupledParamError
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cplCount;
  // Saturating is not needed: at most three coupled parameters
  assign cplCount = 2'(coupleOrder[0] != 0) + 2'(coupleOrder[1] != 0) + 2'(coupleOrder[2] != 0);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_step_one_hot: assert property (stepReq != 0 |-> $onehot(stepReq))
    else $error("step request not one-hot");
  a_step_blocks_cmd: assert property (stepReq != 0 |-> !cmdReady)
    else $error("command accepted while stepping");
  a_meas_in_run: assert property (measStart |-> runActive && coupleOrder != 0)
    else $error("measurement outside a coupled run");
  a_each_steps_one: assert property ($changed(runCounters.each) |->
      runCounters.each == $past(runCounters.each) + 1 || runCounters.each == 0)
    else $error("each counter jumped");
  a_end_each_total: assert property (runEnded && terminationSelect == SEL_EACH |->
      runCounters.each == terminationTotal && !runActive)
    else $error("end without each counter at total");
  a_end_first_total: assert property (runEnded && terminationSelect == SEL_FIRST |->
      runCounters.firstLoop == terminationTotal)
    else $error("end without first loop counter at total");
  a_end_needs_total: assert property (runEnded |-> terminationTotal != 0)
    else $error("auto end with zero total");
  a_no_cpl_idle: assert property (noCoupledParamError |-> coupleOrder == 0 && !runActive)
    else $error("coupling error while coupled or running");
  a_select_range: assert property ($changed(terminationSelect) |-> terminationSelect <= cplCount)
    else $error("select beyond coupled count");
  a_idle_ready: assert property (!runActive |-> cmdReady ##1 (runActive || cmdReady))
    else $error("idle but not ready");
  c_auto_end: cover property (runEnded);
  c_no_cpl: cover property (noCoupledParamError);
  c_meas: cover property (measStart);
endmodule : scan_term_chk

/* File: scan_engine_model.sv */
module scan_engine_model
  import scan_term_pkg::*;
#(parameter int SIZE = 2)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [scan_term_pkg::NUM_PARAMS-1:0] stepReq,
  input wire logic coupledRestart,
  input wire logic measStart,
  output logic stepAck,
  output logic [scan_term_pkg::NUM_PARAMS-1:0] stepWrap,
  output logic [scan_term_pkg::NUM_PARAMS-1:0] stepLast,
  output logic measDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos[NUM_PARAMS];
  int k, sw, mw;
  logic wr, slow;
  // First step after a restart lands on the start value; only fits the lowest-order parameter
  logic [NUM_PARAMS-1:0] fresh;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stepAck <= 1'b0; measDone <= 1'b0; stepWrap <= '0; stepLast <= '0;
      sw = 0; mw = 0; k = 0; slow = 1'b0;
      fresh = '1;
      foreach (pos[i]) pos[i] = 0;
    end else begin
      stepAck <= 1'b0;
      measDone <= 1'b0;
      // Flags only mean something with the ack, so keep them moving
      stepWrap <= ~stepWrap;
      stepLast <= ~stepLast;
      if (coupledRestart) begin
        foreach (pos[i]) pos[i] = 0;
        fresh = '1;
      end
      if (stepReq != 0) begin
        for (int i = 0; i < NUM_PARAMS; i++) if (stepReq[i]) k = i;
        sw = 2;
      end else if (sw > 0) begin
        sw--;
        if (sw == 0) begin
          if (fresh[k]) begin
            wr = 1'b0;
            fresh[k] = 1'b0;
          end else begin
            wr = (pos[k] == SIZE - 1);
            pos[k] = wr ? 0 : pos[k] + 1;
          end
          stepAck <= 1'b1;
          stepWrap <= NUM_PARAMS'(wr) << k;
          stepLast <= NUM_PARAMS'(pos[k] == SIZE - 1) << k;
        end
      end
      // Alternate prompt and slow measurements
      if (measStart) begin
        mw = slow ? 4 : 1;
        slow = !slow;
      end else if (mw > 0) begin
        mw--;
        if (mw == 0) measDone <= 1'b1;
      end
    end
  end
endmodule : scan_engine_model

/* File: tb_scan_sequence_terminator.sv */
module tb_scan_sequence_terminator;
  import scan_term_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, resetn = 0, cmdValid = 0, cmdReady, stepAck, coupledRestart, measStart, measDone;
  logic runActive, runEnded, noCoupledParamError, selectTooLargeError;
  scan_cmd_t cmd = '0;
  couple_orders_t coupleOrder = '0;
  logic [NUM_PARAMS-1:0] stepReq, stepWrap, stepLast;
  run_counters_t runCounters;
  logic [CNT_W-1:0] terminationTotal, held;
  term_sel_t terminationSelect;
  int n_fail = 0, num_checks = 0, nNoCpl = 0, nBig = 0, nRst = 0, nEnd = 0, r0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    nNoCpl += int'(noCoupledParamError === 1'b1);
    nBig += int'(selectTooLargeError === 1'b1);
    nRst += int'(coupledRestart === 1'b1);
    nEnd += int'(runEnded === 1'b1);
  end
  scan_sequence_terminator DUT (.core_clk, .resetn, .cmdValid, .cmd, .cmdReady, .coupleOrder, .stepReq,
    .stepAck, .stepWrap, .stepLast, .coupledRestart, .measStart, .measDone, .runCounters, .terminationTotal,
    .terminationSelect, .runActive, .runEnded, .noCoupledParamError, .selectTooLargeError);
  scan_engine_model #(.SIZE(2)) engine (.core_clk, .resetn, .stepReq, .coupledRestart, .measStart,
    .stepAck, .stepWrap, .stepLast, .measDone);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic check(string what, logic [CNT_W-1:0] seen, logic [CNT_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic timeout(string what);
    n_fail++;
    $display("mismatch %s expected done seen timeout", what);
    finish_test();
  endtask : timeout
  task automatic send(cmd_code_t c, logic ap, logic on, reset_qual_t q, logic [CNT_W-1:0] v);
    int t;
    @(negedge core_clk);
    cmd = '{c, ap, on, q, v};
    cmdValid = 1'b1;
    for (t = 0; t < 500 && cmdReady !== 1'b1; t++) @(negedge core_clk);
    if (cmdReady !== 1'b1) timeout("cmdReady");
    @(negedge core_clk);
    cmdValid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : send
  task automatic waitIdle();
    int t;
    for (t = 0; t < 5000 && runActive !== 1'b0; t++) @(negedge core_clk);
    if (runActive !== 1'b0) timeout("runActive");
    // Let the end pulse reach the edge counters
    @(negedge core_clk);
  endtask : waitIdle
  task automatic waitEach(logic [CNT_W-1:0] n);
    int t;
    for (t = 0; t < 5000 && !(runCounters.each >= n); t++) @(negedge core_clk);
    if (!(runCounters.each >= n)) timeout("each");
  endtask : waitEach
  initial begin
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    check("total", terminationTotal, 32'h0);
    check("select", terminationSelect, SEL_EACH);
    check("counters", 32'(runCounters !== '0), 32'h0);
    $display("test reset values done");
    send(CMD_RUN, 1'b1, 1'b1, QUAL_ALL, 32'h0);
    check("noCplErr", nNoCpl, 1);
    check("active", runActive, 0);
    coupleOrder[0] = 2'h1;
    send(CMD_SET_SELECT, 1'b1, 1'b1, QUAL_ALL, 32'h2);
    check("tooBigErr", nBig, 1);
    check("select", terminationSelect, SEL_EACH);
    $display("test refusals done");
    send(CMD_SET_TOTAL, 1'b1, 1'b1, QUAL_ALL, 32'h3);
    check("total", terminationTotal, 32'h3);
    for (int r = 1; r <= 2; r++) begin
      send(CMD_RUN, 1'b0, 1'b0, QUAL_ALL, 32'h0);
      waitIdle();
      check("each", runCounters.each, 32'h3);
      check("ended", nEnd, r);
    end
    send(CMD_SET_SELECT, 1'b1, 1'b1, QUAL_ALL, 32'h1);
    send(CMD_RUN, 1'b1, 1'b1, QUAL_ALL, 32'h0);
    waitIdle();
    check("firstLoop", runCounters.firstLoop, 32'h3);
    // Three passes over a set of two
    check("each", runCounters.each, 32'h6);
    check("secondLoop", runCounters.secondLoop, 32'h0);
    $display("test auto end done");
    r0 = nRst;
    send(CMD_RESET, 1'b1, 1'b1, QUAL_COUNTER_CLEAR_QUALIFIER, 32'h0);
    check("counters", 32'(runCounters !== '0), 32'h0);
    check("restart", nRst, r0);
    send(CMD_RESET, 1'b1, 1'b1, QUAL_COUPLED, 32'h0);
    check("restart", nRst, r0 + 1);
    send(CMD_RESET, 1'b0, 1'b1, QUAL_ALL, 32'h0);
    check("restart", nRst, r0 + 2);
    $display("test reset qualifiers done");
    send(CMD_SET_SELECT, 1'b1, 1'b1, QUAL_ALL, 32'h0);
    send(CMD_SET_TOTAL, 1'b1, 1'b1, QUAL_ALL, 32'h0);
    r0 = nEnd;
    send(CMD_RUN, 1'b1, 1'b1, QUAL_ALL, 32'h0);
    waitEach(32'h8);
    send(CMD_OTHER, 1'b0, 1'b0, QUAL_ALL, 32'h0);
    check("active", runActive, 1);
    send(CMD_RUN, 1'b1, 1'b0, QUAL_ALL, 32'h0);
    check("active", runActive, 0);
    held = runCounters.each;
    repeat (20) @(negedge core_clk);
    check("each", runCounters.each, held);
    check("ended", nEnd, r0);
    $display("test run stop done");
    for (int i = 0; i < 2; i++) begin
      held = runCounters.each;
      send(CMD_RUN, 1'b0, 1'b0, QUAL_ALL, 32'h0);
      waitEach(held + 1);
      check("each", runCounters.each, held + 1);
      send(i == 0 ? CMD_SINGLE_SHOT : CMD_SINGLE_ADVANCE, 1'b0, 1'b0, QUAL_ALL, 32'h0);
      held = runCounters.each;
      repeat (20) @(negedge core_clk);
      check("active", runActive, 0);
      check("each", runCounters.each, held);
    end
    $display("test single stop done");
    finish_test();
  end
endmodule : tb_scan_sequence_terminator
bind scan_sequence_terminator scan_term_chk chk (.core_clk, .resetn, .cmdReady, .coupleOrder, .stepReq,
  .measStart, .runCounters, .terminationTotal, .terminationSelect, .runActive, .runEnded, .noCoupledParamError);
